/* hw/safety_diag_core.sv */
// Fault, warning and diagnostic logic of a safety sensor, with AXI4-Lite registers.
// Assumes sensor inputs are synchronous to mclk and already debounced.
//
// Functional notes
// - Internal error drops both safety outputs at once
// - Conventional: clear after cause gone, guard reopened
// - Temperature, external potential, cross-circuit are warnings
// - Warning: diagnostic off, safety outputs stay on
// - Warning clears itself when cause disappears
// - Warning lasting 30 minutes forces shutdown, red flash
// - Teaching mode holds safety and diagnostic outputs low
// - Serial variant uses chained serial in/out
// - Response byte refreshed continuously without request
// - Link error keeps safety outputs unchanged
// - Response bits 0, 1, 4: enabled, actuator, inputs
// - Response bits 5, 6, 7: limit, warning, error
// - Serial: clear on guard open or bit7 fall
// - Output faults clear only at next release
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "safety_diag_regs.svh"
module safety_diag_core #(
	parameter logic [17:0] DIV_CYCLES = 18'(`CYCLES_PER_MS),
	parameter logic [20:0] WARN_MS = 21'(`WARN_LIMIT_MS)
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Sensor state
	input wire logic safety_input_a,
	input wire logic safety_input_b,
	input wire logic actuator_present,
	input wire logic actuator_limit,
	input wire logic teach_mode,
	// Fault and warning causes
	input wire logic internal_fault,
	input wire logic output_fault,
	input wire logic over_temp,
	input wire logic ext_potential,
	input wire logic cross_circuit,
	// Safety and diagnostic outputs
	output logic safety_output_a,
	output logic safety_output_b,
	output logic diag_out,
	output logic red_led_flash,
	// Serial diagnostic chain
	input wire logic serial_diag_chain_in,
	input wire logic serial_diag_chain_shift,
	input wire logic serial_diag_chain_frame,
	output logic serial_diag_chain_out,
	// AXI4-Lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// Register state
	logic [31:0] ctrl_reg;
	logic [7:0] aw_addr_reg;
	logic aw_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic w_held_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic awready_reg, wready_reg, arready_reg;

	// Sensor state
	safety_diag_pkg::fault_state_t fault_reg;
	safety_diag_pkg::fault_state_t fault_next;
	logic out_fault_reg;
	logic actuated_d_reg;
	logic req7_prev_reg;
	logic enable_reg;
	logic diag_reg;
	logic red_reg;
	logic [17:0] div_reg;
	logic ms_tick_reg;
	logic blink_reg;

	// Helper outputs
	logic warn_expired;
	logic [20:0] warn_elapsed;
	safety_diag_pkg::diag_byte_t req_byte;
	logic req_valid;
	logic comm_err;

	// Millisecond tick; the blink toggles each ms for the pulsed diagnostic level
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 18'h0;
			ms_tick_reg <= 1'b0;
			blink_reg <= 1'b0;
		end else begin
			ms_tick_reg <= div_reg == DIV_CYCLES - 18'h1;
			div_reg <= (div_reg == DIV_CYCLES - 18'h1) ? 18'h0 : div_reg + 18'h1;
			blink_reg <= blink_reg ^ ms_tick_reg;
		end
	end

	// Cause decoding
	wire serial_mode = ctrl_reg[`CTRL_SERIAL_BIT];
	wire inputs_ok = safety_input_a && safety_input_b;
	wire warn_any = over_temp || ext_potential || cross_circuit;
	wire err_cause = internal_fault || out_fault_reg || warn_expired;
	wire guard_open = !actuator_present;
	wire guard_open_edge = !actuator_present && actuated_d_reg;
	wire guard_close_edge = actuator_present && !actuated_d_reg;
	wire req7_fall = req_valid && !req_byte[`REQ_ERR_RESET_BIT] && req7_prev_reg;
	wire error_on = fault_reg != safety_diag_pkg::fault_clear;

	// Warning delay; cancelled as soon as the warning goes away
	warn_timer #(
		.LIMIT_MS(WARN_MS)
	) u_warn_timer (
		.clk(mclk),
		.rst_n(rst_n),
		.warn_active(warn_any),
		.ms_tick(ms_tick_reg),
		.expired(warn_expired),
		.elapsed_ms(warn_elapsed)
	);

	// Error latch; at the close edge the output-fault flag is being dropped, so raw causes decide
	always_comb begin
		fault_next = fault_reg;
		case (fault_reg)
			safety_diag_pkg::fault_clear: begin
				if (err_cause) begin
					fault_next = safety_diag_pkg::fault_latched;
				end
			end
			safety_diag_pkg::fault_latched: begin
				if (serial_mode) begin
					if (!err_cause && (guard_open || req7_fall)) begin
						fault_next = safety_diag_pkg::fault_clear;
					end
				end else if (guard_open_edge) begin
					fault_next = safety_diag_pkg::fault_wait_close;
				end
			end
			safety_diag_pkg::fault_wait_close: begin
				if (serial_mode && !err_cause) begin
					fault_next = safety_diag_pkg::fault_clear;
				end else if (guard_close_edge) begin
					fault_next = (internal_fault || output_fault || warn_expired)
						? safety_diag_pkg::fault_latched : safety_diag_pkg::fault_clear;
				end
			end
			default: begin
				fault_next = safety_diag_pkg::fault_latched;
			end
		endcase
	end

	// Output stage faults stay latched until the next release; a new fault wins over the clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_reg <= safety_diag_pkg::fault_clear;
			out_fault_reg <= 1'b0;
			actuated_d_reg <= 1'b0;
			req7_prev_reg <= 1'b0;
		end else begin
			fault_reg <= fault_next;
			actuated_d_reg <= actuator_present;
			if (output_fault) begin
				out_fault_reg <= 1'b1;
			end else if (guard_close_edge) begin
				out_fault_reg <= 1'b0;
			end
			if (req_valid) begin
				req7_prev_reg <= req_byte[`REQ_ERR_RESET_BIT];
			end
		end
	end

	// Output decisions; link errors are left out so outputs keep their state
	wire enable_next = actuator_present && inputs_ok && !error_on && !err_cause && !teach_mode;
	wire diag_conv = actuator_present && !warn_any && !error_on && !teach_mode;
	wire diag_next = !serial_mode && diag_conv && (!actuator_limit || blink_reg);
	wire red_next = error_on || warn_expired;

	// All pins come straight from flip-flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= 1'b0;
			diag_reg <= 1'b0;
			red_reg <= 1'b0;
		end else begin
			enable_reg <= enable_next;
			diag_reg <= diag_next;
			red_reg <= red_next;
		end
	end

	assign safety_output_a = enable_reg;
	assign safety_output_b = enable_reg;
	assign diag_out = diag_reg;
	assign red_led_flash = red_reg;

	// Response byte, rebuilt every cycle
	wire [7:0] resp_byte = {error_on,
		warn_any,
		actuator_present && actuator_limit,
		inputs_ok,
		2'h0,
		actuator_present,
		enable_reg};

	// Chain station; its output is the shifter's top flop
	serial_diag_link u_link (
		.clk(mclk),
		.rst_n(rst_n),
		.chain_in(serial_diag_chain_in),
		.chain_shift(serial_diag_chain_shift),
		.chain_frame(serial_diag_chain_frame),
		.chain_out(serial_diag_chain_out),
		.resp_byte(resp_byte),
		.req_byte(req_byte),
		.req_valid(req_valid),
		.comm_err(comm_err)
	);

	// Write decode once address and data are both held
	wire wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
	wire wr_ctrl = safety_diag_pkg::addr_hit(aw_addr_reg, `REG_CTRL_OFF);
	wire wr_ro = safety_diag_pkg::addr_hit(aw_addr_reg, `REG_STATUS_OFF)
		|| safety_diag_pkg::addr_hit(aw_addr_reg, `REG_REQUEST_OFF)
		|| safety_diag_pkg::addr_hit(aw_addr_reg, `REG_WARN_TIME_OFF);

	// Address and data may arrive in either order
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_reg <= 1'b0;
			awready_reg <= 1'b1;
			aw_addr_reg <= 8'h00;
			w_held_reg <= 1'b0;
			wready_reg <= 1'b1;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_held_reg) begin
				aw_held_reg <= 1'b1;
				awready_reg <= 1'b0;
				aw_addr_reg <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held_reg <= 1'b0;
				awready_reg <= 1'b1;
			end
			if (s_axi_wvalid && !w_held_reg) begin
				w_held_reg <= 1'b1;
				wready_reg <= 1'b0;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held_reg <= 1'b0;
				wready_reg <= 1'b1;
			end
		end
	end

	// Register update and write response; only byte lane 0 carries control bits
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= `CTRL_RESET_VAL;
			bvalid_reg <= 1'b0;
			bresp_reg <= `AXI_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (wr_ctrl || wr_ro) ? `AXI_RESP_OKAY : `AXI_RESP_DECERR;
			if (wr_ctrl && w_strb_reg[0]) begin
				ctrl_reg[`CTRL_SERIAL_BIT] <= w_data_reg[`CTRL_SERIAL_BIT];
			end
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Read decode
	wire [31:0] stat_word = {20'h0, teach_mode, warn_expired, out_fault_reg, comm_err, resp_byte};
	wire rd_ctrl = safety_diag_pkg::addr_hit(s_axi_araddr, `REG_CTRL_OFF);
	wire rd_stat = safety_diag_pkg::addr_hit(s_axi_araddr, `REG_STATUS_OFF);
	wire rd_req = safety_diag_pkg::addr_hit(s_axi_araddr, `REG_REQUEST_OFF);
	wire rd_time = safety_diag_pkg::addr_hit(s_axi_araddr, `REG_WARN_TIME_OFF);
	wire rd_hit = rd_ctrl || rd_stat || rd_req || rd_time;
	wire [31:0] rd_word = rd_ctrl ? ctrl_reg
		: rd_stat ? stat_word
		: rd_req ? {24'h0, req_byte}
		: rd_time ? {11'h0, warn_elapsed}
		: 32'h0000_0000;

	// One read at a time; the address is taken only while no answer is pending
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `AXI_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			arready_reg <= 1'b0;
			rdata_reg <= rd_word;
			rresp_reg <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_DECERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

endmodule

/* inc/safety_diag_regs.svh */
// Register offsets, field positions, reset values and timing counts of the safety diagnostic core.
// Assumes a 32-bit AXI4-Lite register window with byte addresses.
`ifndef SAFETY_DIAG_REGS_SVH
`define SAFETY_DIAG_REGS_SVH

// Register byte offsets
`define REG_CTRL_OFF 8'h00
`define REG_STATUS_OFF 8'h04
`define REG_REQUEST_OFF 8'h08
`define REG_WARN_TIME_OFF 8'h0C

// Control register fields
`define CTRL_SERIAL_BIT 0
`define CTRL_RESET_VAL 32'h0000_0000

// Status register fields above the response byte
`define STAT_COMM_ERR_BIT 8
`define STAT_OUT_FAULT_BIT 9
`define STAT_WARN_EXPIRED_BIT 10
`define STAT_TEACH_BIT 11

// Response byte fields
`define RESP_ENABLED_BIT 0
`define RESP_ACTUATOR_BIT 1
`define RESP_INPUTS_BIT 4
`define RESP_LIMIT_BIT 5
`define RESP_WARN_BIT 6
`define RESP_ERROR_BIT 7
`define REQ_ERR_RESET_BIT 7

// AXI responses
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_DECERR 2'h3

// Timing: clock rate, warning limit, derived counts
`define CLK_FREQ_KHZ 250000
`define WARN_LIMIT_MIN 30
`define MS_PER_MIN 60000
`define CYCLES_PER_MS (`CLK_FREQ_KHZ / 1000 * 1000)
`define WARN_LIMIT_MS (`WARN_LIMIT_MIN * `MS_PER_MIN)
`define DIV_WIDTH 18
`define WARN_WIDTH 21

`endif

/* inc/safety_diag_pkg.sv */
// Types shared by the safety diagnostic core and its helpers.
// Assumes safety_diag_regs.svh holds all numeric constants.
package safety_diag_pkg;

	// Latched error handling
	typedef enum logic [1:0] {fault_clear, fault_latched, fault_wait_close} fault_state_t;

	typedef logic [7:0] diag_byte_t;

	// Word-aligned address match, used by both read and write decode
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
		return addr[7:2] == off[7:2];
	endfunction

endpackage

/* hw/warn_timer.sv */
// Delayed-shutdown timer for error warnings.
// Assumes ms_tick is a one-cycle pulse once per millisecond.
`timescale 1ns/100ps
`include "safety_diag_regs.svh"
module warn_timer #(
	parameter logic [20:0] LIMIT_MS = 21'(`WARN_LIMIT_MS)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic warn_active,
	input wire logic ms_tick,
	// Result
	output logic expired,
	output logic [20:0] elapsed_ms
);

	logic [20:0] count_reg;
	logic expired_reg;

	// Restarts from zero whenever the warning drops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 21'h0;
			expired_reg <= 1'b0;
		end else if (!warn_active) begin
			count_reg <= 21'h0;
			expired_reg <= 1'b0;
		end else if (ms_tick && !expired_reg) begin
			count_reg <= count_reg + 21'h1;
			expired_reg <= (count_reg + 21'h1) >= LIMIT_MS;
		end
	end

	assign expired = expired_reg;
	assign elapsed_ms = count_reg;

endmodule

/* hw/serial_diag_link.sv */
// One station of the serial diagnostic chain: an 8-bit pass-through shifter.
// Assumes the gateway frames the chain and strobes one bit per shift pulse.
`timescale 1ns/100ps
module serial_diag_link (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Chain pins
	input wire logic chain_in,
	input wire logic chain_shift,
	input wire logic chain_frame,
	output logic chain_out,
	// Local data
	input wire safety_diag_pkg::diag_byte_t resp_byte,
	output safety_diag_pkg::diag_byte_t req_byte,
	output logic req_valid,
	output logic comm_err
);

	safety_diag_pkg::diag_byte_t shift_reg;
	safety_diag_pkg::diag_byte_t req_reg;
	logic frame_d_reg;
	logic [2:0] bit_cnt_reg;
	logic got_bits_reg;
	logic valid_reg;
	logic err_reg;

	wire frame_start = chain_frame && !frame_d_reg;
	wire frame_end = !chain_frame && frame_d_reg;
	wire frame_good = got_bits_reg && (bit_cnt_reg == 3'h0);

	// Response loaded at frame start; upstream bytes pass on delayed by 8 bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			got_bits_reg <= 1'b0;
			frame_d_reg <= 1'b0;
		end else begin
			frame_d_reg <= chain_frame;
			if (frame_start) begin
				shift_reg <= resp_byte;
				bit_cnt_reg <= 3'h0;
				got_bits_reg <= 1'b0;
			end else if (chain_frame && chain_shift) begin
				shift_reg <= {shift_reg[6:0], chain_in};
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				got_bits_reg <= 1'b1;
			end
		end
	end

	// Last byte of a whole frame is ours; a ragged frame is a link error
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_reg <= 8'h00;
			valid_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			valid_reg <= frame_end && frame_good;
			if (frame_end) begin
				err_reg <= !frame_good;
				if (frame_good) begin
					req_reg <= shift_reg;
				end
			end
		end
	end

	assign chain_out = shift_reg[7];
	assign req_byte = req_reg;
	assign req_valid = valid_reg;
	assign comm_err = err_reg;

endmodule

/* testbench/diag_gateway_model.sv */
// Gateway model: frames the serial diagnostic chain and swaps one byte per station.
// Assumes a single station on the chain, clocked from mclk.
`timescale 1ns/100ps
module diag_gateway_model (
	// Clock
	input wire logic mclk,
	// Chain pins
	input wire logic serial_diag_chain_out,
	output logic serial_diag_chain_in,
	output logic serial_diag_chain_shift,
	output logic serial_diag_chain_frame
);
	logic busy;
	initial begin
		busy = 1'b0;
		serial_diag_chain_in = 1'b0;
		serial_diag_chain_shift = 1'b0;
		serial_diag_chain_frame = 1'b0;
	end
	// Idle data toggles so a stale bit never looks valid
	always @(posedge mclk) begin
		if (!busy)
			serial_diag_chain_in <= ~serial_diag_chain_in;
	end
	// One frame of n shifts; one request byte for the one station, MSB first
	task automatic xfer(input logic [7:0] req, input int n, output logic [7:0] rsp);
		rsp = 8'h00;
		busy = 1'b1;
		serial_diag_chain_frame <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			rsp = {rsp[6:0], serial_diag_chain_out};
			serial_diag_chain_in <= req[7 - (i % 8)];
			serial_diag_chain_shift <= 1'b1;
			@(posedge mclk);
			serial_diag_chain_shift <= 1'b0;
		end
		@(posedge mclk);
		serial_diag_chain_frame <= 1'b0;
		@(posedge mclk);
		busy = 1'b0;
	endtask
endmodule

/* testbench/safety_diag_core_asserts.sv */
// Checker on the safety diagnostic core ports.
// Assumes binding onto safety_diag_core; one clock domain.
`timescale 1ns/100ps
module safety_diag_core_asserts #(
	parameter logic [17:0] DIV_CYCLES = 18'h4,
	parameter logic [20:0] WARN_MS = 21'h5
) (
	// Clock, reset, causes
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic safety_input_a,
	input wire logic safety_input_b,
	input wire logic actuator_present,
	input wire logic teach_mode,
	input wire logic internal_fault,
	input wire logic output_fault,
	input wire logic over_temp,
	input wire logic ext_potential,
	input wire logic cross_circuit,
	// Outputs
	input wire logic safety_output_a,
	input wire logic safety_output_b,
	input wire logic diag_out,
	input wire logic red_led_flash,
	// Bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// Margins cover the free-running ms divider phase
	localparam longint SAFE_LIM = longint'(DIV_CYCLES) * (longint'(WARN_MS) - 2);
	localparam longint EXP_LIM = longint'(DIV_CYCLES) * (longint'(WARN_MS) + 1) + 3;
	logic warn;
	logic [39:0] warn_cycles_reg;
	assign warn = over_temp | ext_potential | cross_circuit;
	// Length of the running warning; any gap restarts it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			warn_cycles_reg <= 40'h0;
		else if (!warn)
			warn_cycles_reg <= 40'h0;
		else if (warn_cycles_reg <= EXP_LIM)
			warn_cycles_reg <= warn_cycles_reg + 40'h1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence shut_off;
		!safety_output_a && !safety_output_b;
	endsequence
	a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write response late");
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_fault_shutoff: assert property (internal_fault |=> shut_off ##[0:1] red_led_flash)
		else $error("internal fault left outputs on");
	a_outputs_pair: assert property (safety_output_a == safety_output_b)
		else $error("safety outputs differ");
	a_teach_low: assert property (teach_mode |=> shut_off and !diag_out)
		else $error("teach mode output high");
	a_warn_diag: assert property (warn |=> !diag_out)
		else $error("diagnostic active during warning");
	a_warn_keeps_on: assert property (warn && warn_cycles_reg < SAFE_LIM && safety_output_a && safety_input_a
		&& safety_input_b && actuator_present && !teach_mode && !internal_fault && !output_fault |=> safety_output_a)
		else $error("warning shut outputs early");
	a_warn_expiry: assert property (warn_cycles_reg == EXP_LIM |-> shut_off and red_led_flash)
		else $error("warning limit not enforced");
endmodule
bind safety_diag_core safety_diag_core_asserts #(.DIV_CYCLES(DIV_CYCLES), .WARN_MS(WARN_MS)) chk (.*);

/* testbench/safety_diag_core_tb.sv */
// Testbench: sensor causes, AXI4-Lite registers and the chain through a gateway model.
// Assumes short timing: 4 cycles per ms and a 5 ms warning limit.
`timescale 1ns/100ps
`include "safety_diag_regs.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module safety_diag_core_tb;
	logic mclk, rst_n, safety_input_a, safety_input_b, actuator_present, actuator_limit, teach_mode;
	logic internal_fault, output_fault, over_temp, ext_potential, cross_circuit;
	logic safety_output_a, safety_output_b, diag_out, red_led_flash;
	logic serial_diag_chain_in, serial_diag_chain_shift, serial_diag_chain_frame, serial_diag_chain_out;
	logic [7:0] s_axi_awaddr, s_axi_araddr, b;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int tests_run = 0;
	int miscompares = 0;
	safety_diag_core #(.DIV_CYCLES(18'h4), .WARN_MS(21'h5)) uut (.*);
	diag_gateway_model gw (.*);
	initial begin
		{mclk, rst_n, safety_input_a, safety_input_b, actuator_present, actuator_limit, teach_mode} = '0;
		{internal_fault, output_fault, over_temp, ext_potential, cross_circuit} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	always #2 mclk = ~mclk;
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge mclk);
			aw_ok |= s_axi_awready;
			w_ok |= s_axi_wready;
			if (aw_ok)
				s_axi_awvalid <= 1'b0;
			if (w_ok)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid) @(posedge mclk);
		rs = s_axi_bresp;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [1:0] er, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		`CHK(s_axi_rresp, er)
		`CHK(d & m, e)
	endtask
	task automatic outs(input logic e, input logic dg);
		`CHK({safety_output_a, safety_output_b}, {e, e})
		`CHK(diag_out, dg)
	endtask
	// Open and reclose the guard
	task automatic guard;
		actuator_present <= 1'b0;
		tick(3);
		actuator_present <= 1'b1;
		tick(4);
	endtask
	task automatic pulse_fault;
		internal_fault <= 1'b1;
		tick(1);
		internal_fault <= 1'b0;
		tick(4);
	endtask
	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Whole run needs well under 2000 cycles
	initial begin
		#40000;
		miscompares++;
		stop_test();
	end
	initial begin
		tick(20);
		rst_n <= 1'b1;
		tick(2);
		rd_chk(`REG_CTRL_OFF, `AXI_RESP_OKAY, 32'hFFFF_FFFF, 32'h0);
		rd_chk(8'h10, `AXI_RESP_DECERR, 32'hFFFF_FFFF, 32'h0);
		axi_wr(8'h10, 32'h1, r);
		`CHK(r, `AXI_RESP_DECERR)
		{safety_input_a, safety_input_b, actuator_present} <= 3'h7;
		tick(4);
		outs(1'b1, 1'b1);
		rd_chk(`REG_STATUS_OFF, `AXI_RESP_OKAY, 32'hFF, 32'h13);
		actuator_limit <= 1'b1;
		tick(4);
		rd_chk(`REG_STATUS_OFF, `AXI_RESP_OKAY, 32'hFF, 32'h33);
		actuator_limit <= 1'b0;
		// Each warning cause, then its removal
		for (int i = 0; i < 3; i++) begin
			{over_temp, ext_potential, cross_circuit} <= 3'h4 >> i;
			tick(4);
			outs(1'b1, 1'b0);
			rd_chk(`REG_STATUS_OFF, `AXI_RESP_OKAY, 32'hFF, 32'h53);
			{over_temp, ext_potential, cross_circuit} <= 3'h0;
			tick(4);
			outs(1'b1, 1'b1);
		end
		// Gap restarts the timer; a full span then shuts off
		over_temp <= 1'b1;
		tick(14);
		over_temp <= 1'b0;
		tick(2);
		over_temp <= 1'b1;
		tick(14);
		outs(1'b1, 1'b0);
		tick(20);
		outs(1'b0, 1'b0);
		`CHK(red_led_flash, 1'b1)
		over_temp <= 1'b0;
		pulse_fault();
		outs(1'b0, 1'b0);
		rd_chk(`REG_STATUS_OFF, `AXI_RESP_OKAY, 32'hFF, 32'h92);
		tick(10);
		outs(1'b0, 1'b0);
		guard();
		outs(1'b1, 1'b1);
		teach_mode <= 1'b1;
		tick(3);
		outs(1'b0, 1'b0);
		teach_mode <= 1'b0;
		guard();
		// Output fault in conventional mode clears with the next release
		output_fault <= 1'b1;
		tick(1);
		output_fault <= 1'b0;
		tick(2);
		`CHK(safety_output_a, 1'b0)
		guard();
		outs(1'b1, 1'b1);
		// Serial variant
		axi_wr(`REG_CTRL_OFF, 32'h1, r);
		rd_chk(`REG_CTRL_OFF, `AXI_RESP_OKAY, 32'h1, 32'h1);
		tick(3);
		outs(1'b1, 1'b0);
		gw.xfer(8'h00, 8, b);
		`CHK(b, 8'h13)
		gw.xfer(8'h00, 5, b);
		tick(2);
		outs(1'b1, 1'b0);
		rd_chk(`REG_STATUS_OFF, `AXI_RESP_OKAY, 32'h100, 32'h100);
		pulse_fault();
		outs(1'b0, 1'b0);
		gw.xfer(8'h80, 8, b);
		`CHK(b, 8'h92)
		rd_chk(`REG_REQUEST_OFF, `AXI_RESP_OKAY, 32'hFF, 32'h80);
		gw.xfer(8'h00, 8, b);
		tick(3);
		outs(1'b1, 1'b0);
		output_fault <= 1'b1;
		tick(1);
		output_fault <= 1'b0;
		gw.xfer(8'h80, 8, b);
		gw.xfer(8'h00, 8, b);
		rd_chk(`REG_STATUS_OFF, `AXI_RESP_OKAY, 32'h200, 32'h200);
		guard();
		rd_chk(`REG_STATUS_OFF, `AXI_RESP_OKAY, 32'h200, 32'h0);
		stop_test();
	end
endmodule
